// *** inc/bbm_pkg.sv ***
/*
 * Constants for the processor bus break and overlay comparator:
 * the register map, control field positions, reset values and widths.
 * Assumes an APB master with a 12-bit byte address and 32-bit data.
 */
package bbm_pkg;

  // ==========================================================
  // widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PHYS_W = 36;
  localparam int LOW_W = 24;
  localparam int HIGH_W = 4;
  localparam int EVT_W = 2;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFF_LOW_CMP = 12'h300;
  localparam logic [11:0] OFF_DATA_CMP = 12'h304;
  localparam logic [11:0] OFF_DMASK_UOAM = 12'h308;
  localparam logic [11:0] OFF_CTRL_MASK = 12'h30c;
  localparam logic [11:0] OFF_HIGH_CMP = 12'h310;
  localparam logic [11:0] OFF_HIGH_MASK = 12'h314;
  localparam logic [11:0] OFF_BRK_STAT = 12'h318;
  localparam logic [11:0] OFF_EVT_STAT = 12'h31c;
  localparam logic [11:0] OFF_EVT_CLR = 12'h320;
  localparam logic [11:0] OFF_EVT_EN = 12'h324;

  // ==========================================================
  // control register fields
  localparam int CTRL_BREAK_EN = 0;
  localparam int CTRL_OVERLAY_EN = 3;
  localparam int CTRL_UNC_LOAD_LO = 4;
  localparam int CTRL_UNC_STORE = 6;
  localparam int CTRL_CACHED_STORE = 7;
  localparam int CTRL_LAM_LO = 8;
  localparam int CTRL_LAM_HI = 31;
  localparam int UOAM_LO = 24;

  // read-only uncached load/fetch qualifier: loads and fetches are compared
  localparam logic [1:0] UNC_LOAD_FETCH_VAL = 2'h3;

  // break status register fields
  localparam int BSTAT_BREAK = 0;
  localparam int BSTAT_DEBUG_INTERRUPT_FLAG = 1;

  // event bits
  localparam int EVT_BREAK = 0;
  localparam int EVT_OVERLAY = 1;

  // ==========================================================
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_CTRL_LOW = 8'h00;
  localparam logic [23:0] RST_LAM = 24'h00_0000;
  localparam logic [3:0] RST_HIGH = 4'h0;
  localparam logic [1:0] RST_EVT = 2'h0;

endpackage : bbm_pkg

// *** rtl/bbm_masked_eq.sv ***
/*
 * Masked equality compare: a mask bit of one drops that bit from the
 * compare; every remaining bit must be equal.
 * Assumes all inputs come from the same clock domain.
 */
module bbm_masked_eq #(
  parameter int W = 32
) (
  // operands
  input wire logic [W-1:0] value_a,
  input wire logic [W-1:0] value_b,
  input wire logic [W-1:0] mask,
  // result
  output logic equal
);

  logic [W-1:0] bit_ok;

  // ==========================================================
  // per-bit compare
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign bit_ok[i] = mask[i] | (value_a[i] == value_b[i]);
    end
  endgenerate

  assign equal = &bit_ok;

endmodule : bbm_masked_eq

// *** rtl/bbm_break_match.sv ***
/*
 * Processor bus break and overlay comparator with its APB register file.
 * Watches the core's physical address and data bus; on a break match it
 * flags status and requests a debug exception, on an overlay match it
 * redirects the request to the debug probe.
 * Assumes the core bus and the debug mode level are on ref_clk.
 */
// How it works
// - control bits 31:8 mask the low 24 address bits; one excludes.
// - control bit 7 enables compares on stores to cached memory.
// - control bit 6 enables compares on stores to uncached memory.
// - bits 5:4 read 11: uncached loads and fetches are compared.
// - overlay enable bit 3 redirects full 36-bit masked matches; resets 0.
// - break enable raises debug exception on masked address and data match.
// - a break match sets break status and the debug interrupt bit.
// - break exception is held off while debug mode is one.
// - control bit 0 enables breaking and resets to zero.
// - control bits 2 and 1 read zero and ignore writes.
// - high compare holds four bits; bits 31:4 read zero.
// - data mask ones exclude data bits from the break compare.
// - with overlay, upper mask supplies address mask bits 31:24.
// - four-bit high mask excludes upper physical address bits.
// - break exceptions are imprecise, raised two cycles after the match.
module bbm_break_match (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor bus
  input wire logic bus_valid,
  input wire logic bus_store,
  input wire logic bus_cached,
  input wire logic [35:0] bus_addr,
  input wire logic [31:0] bus_data,
  input wire logic debug_mode_indicator,
  // debug side
  output logic overlay_redirect,
  output logic debug_exception,
  output logic debug_interrupt_flag,
  output logic irq
);

  // ==========================================================
  // register state
  logic [31:0] low_cmp_reg, low_cmp_next;
  logic [31:0] data_cmp_reg, data_cmp_next;
  logic [31:0] dmask_reg, dmask_next;
  logic [23:0] lam_reg, lam_next;
  logic cached_en_reg, cached_en_next;
  logic uncached_en_reg, uncached_en_next;
  logic overlay_en_reg, overlay_en_next;
  logic break_en_reg, break_en_next;
  logic [3:0] high_cmp_reg, high_cmp_next;
  logic [3:0] high_mask_reg, high_mask_next;
  logic brk_stat_reg, brk_stat_next;
  logic debug_interrupt_flag_reg, debug_interrupt_flag_next;
  logic [1:0] evt_stat_reg, evt_stat_next;
  logic [1:0] evt_en_reg, evt_en_next;
  logic pend_reg, pend_next;
  logic exc_reg, exc_next;
  logic [31:0] rdata_reg, rdata_next;

  logic setup, wr_en;
  logic mapped;
  logic [31:0] ctrl_word;
  logic [31:0] rd_mux;

  // ==========================================================
  // compare path
  logic qualified;
  logic [35:0] brk_mask, ovl_mask, cmp_addr;
  logic brk_addr_eq, ovl_addr_eq, data_eq;
  logic break_hit, overlay_hit;

  // uncached load/fetch qualifier is fixed, both bits must be set
  logic unc_load_on;
  assign unc_load_on = &bbm_pkg::UNC_LOAD_FETCH_VAL;

  always_comb begin
    // store and load/fetch qualifiers; cached loads are never compared
    qualified = bus_valid & (
      (bus_store & bus_cached & cached_en_reg) |
      (bus_store & ~bus_cached & uncached_en_reg) |
      (~bus_store & ~bus_cached & unc_load_on));
  end

  assign cmp_addr = {high_cmp_reg, low_cmp_reg};
  // break mask keeps address bits 31:24 compared
  assign brk_mask = {high_mask_reg, 8'h00, lam_reg};
  assign ovl_mask = {high_mask_reg, dmask_reg[31:bbm_pkg::UOAM_LO], lam_reg};

  bbm_masked_eq #(
    .W(bbm_pkg::PHYS_W)
  ) u_brk_addr (
    .value_a(bus_addr),
    .value_b(cmp_addr),
    .mask(brk_mask),
    .equal(brk_addr_eq)
  );

  bbm_masked_eq #(
    .W(bbm_pkg::PHYS_W)
  ) u_ovl_addr (
    .value_a(bus_addr),
    .value_b(cmp_addr),
    .mask(ovl_mask),
    .equal(ovl_addr_eq)
  );

  bbm_masked_eq #(
    .W(bbm_pkg::DATA_W)
  ) u_data (
    .value_a(bus_data),
    .value_b(data_cmp_reg),
    .mask(dmask_reg),
    .equal(data_eq)
  );

  // break and overlay share the compare registers; both enables set is undefined
  assign break_hit = break_en_reg & qualified & brk_addr_eq & data_eq;
  assign overlay_hit = overlay_en_reg & qualified & ovl_addr_eq;
  // redirect must act in the same cycle as the request, so it is combinational
  assign overlay_redirect = overlay_hit;

  // ==========================================================
  // apb decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    unique case (paddr)
      bbm_pkg::OFF_LOW_CMP, bbm_pkg::OFF_DATA_CMP, bbm_pkg::OFF_DMASK_UOAM,
      bbm_pkg::OFF_CTRL_MASK, bbm_pkg::OFF_HIGH_CMP, bbm_pkg::OFF_HIGH_MASK,
      bbm_pkg::OFF_BRK_STAT, bbm_pkg::OFF_EVT_STAT, bbm_pkg::OFF_EVT_CLR,
      bbm_pkg::OFF_EVT_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // bits 2 and 1 are not stored and read as zero
  assign ctrl_word = {lam_reg, cached_en_reg, uncached_en_reg, bbm_pkg::UNC_LOAD_FETCH_VAL,
                      overlay_en_reg, 2'h0, break_en_reg};

  always_comb begin
    rd_mux = bbm_pkg::RST_WORD;
    unique case (paddr)
      bbm_pkg::OFF_LOW_CMP: rd_mux = low_cmp_reg;
      bbm_pkg::OFF_DATA_CMP: rd_mux = data_cmp_reg;
      bbm_pkg::OFF_DMASK_UOAM: rd_mux = dmask_reg;
      bbm_pkg::OFF_CTRL_MASK: rd_mux = ctrl_word;
      bbm_pkg::OFF_HIGH_CMP: rd_mux = {28'h000_0000, high_cmp_reg};
      bbm_pkg::OFF_HIGH_MASK: rd_mux = {28'h000_0000, high_mask_reg};
      bbm_pkg::OFF_BRK_STAT: rd_mux = {30'h0000_0000, debug_interrupt_flag_reg, brk_stat_reg};
      bbm_pkg::OFF_EVT_STAT: rd_mux = {30'h0000_0000, evt_stat_reg};
      bbm_pkg::OFF_EVT_EN: rd_mux = {30'h0000_0000, evt_en_reg};
      default: rd_mux = bbm_pkg::RST_WORD;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    low_cmp_next = low_cmp_reg;
    data_cmp_next = data_cmp_reg;
    dmask_next = dmask_reg;
    lam_next = lam_reg;
    cached_en_next = cached_en_reg;
    uncached_en_next = uncached_en_reg;
    overlay_en_next = overlay_en_reg;
    break_en_next = break_en_reg;
    high_cmp_next = high_cmp_reg;
    high_mask_next = high_mask_reg;
    brk_stat_next = brk_stat_reg;
    debug_interrupt_flag_next = debug_interrupt_flag_reg;
    evt_stat_next = evt_stat_reg;
    evt_en_next = evt_en_reg;
    rdata_next = setup ? rd_mux : rdata_reg;
    if (wr_en) begin
      unique case (paddr)
        bbm_pkg::OFF_LOW_CMP: low_cmp_next = pwdata;
        bbm_pkg::OFF_DATA_CMP: data_cmp_next = pwdata;
        bbm_pkg::OFF_DMASK_UOAM: dmask_next = pwdata;
        bbm_pkg::OFF_CTRL_MASK: begin
          lam_next = pwdata[bbm_pkg::CTRL_LAM_HI:bbm_pkg::CTRL_LAM_LO];
          cached_en_next = pwdata[bbm_pkg::CTRL_CACHED_STORE];
          uncached_en_next = pwdata[bbm_pkg::CTRL_UNC_STORE];
          overlay_en_next = pwdata[bbm_pkg::CTRL_OVERLAY_EN];
          break_en_next = pwdata[bbm_pkg::CTRL_BREAK_EN];
        end
        bbm_pkg::OFF_HIGH_CMP: high_cmp_next = pwdata[3:0];
        bbm_pkg::OFF_HIGH_MASK: high_mask_next = pwdata[3:0];
        bbm_pkg::OFF_BRK_STAT: begin
          // writing zero clears a flag, writing one leaves it
          brk_stat_next = brk_stat_reg & pwdata[bbm_pkg::BSTAT_BREAK];
          debug_interrupt_flag_next = debug_interrupt_flag_reg & pwdata[bbm_pkg::BSTAT_DEBUG_INTERRUPT_FLAG];
        end
        bbm_pkg::OFF_EVT_CLR: evt_stat_next = evt_stat_reg & ~pwdata[1:0];
        bbm_pkg::OFF_EVT_EN: evt_en_next = pwdata[1:0];
        default: ;
      endcase
    end
    // hardware sets after the software clear so a same-cycle event wins
    if (break_hit) begin
      brk_stat_next = 1'b1;
      debug_interrupt_flag_next = 1'b1;
      evt_stat_next[bbm_pkg::EVT_BREAK] = 1'b1;
    end
    if (overlay_hit) begin
      evt_stat_next[bbm_pkg::EVT_OVERLAY] = 1'b1;
    end
  end

  // exception request waits for the handler to leave debug mode
  always_comb begin
    exc_next = pend_reg & ~debug_mode_indicator;
    pend_next = break_hit | (pend_reg & ~exc_next);
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_cmp_reg <= bbm_pkg::RST_WORD;
      data_cmp_reg <= bbm_pkg::RST_WORD;
      dmask_reg <= bbm_pkg::RST_WORD;
      lam_reg <= bbm_pkg::RST_LAM;
      cached_en_reg <= 1'b0;
      uncached_en_reg <= 1'b0;
      overlay_en_reg <= 1'b0;
      break_en_reg <= 1'b0;
      high_cmp_reg <= bbm_pkg::RST_HIGH;
      high_mask_reg <= bbm_pkg::RST_HIGH;
      brk_stat_reg <= 1'b0;
      debug_interrupt_flag_reg <= 1'b0;
      evt_stat_reg <= bbm_pkg::RST_EVT;
      evt_en_reg <= bbm_pkg::RST_EVT;
      pend_reg <= 1'b0;
      exc_reg <= 1'b0;
      rdata_reg <= bbm_pkg::RST_WORD;
    end else begin
      low_cmp_reg <= low_cmp_next;
      data_cmp_reg <= data_cmp_next;
      dmask_reg <= dmask_next;
      lam_reg <= lam_next;
      cached_en_reg <= cached_en_next;
      uncached_en_reg <= uncached_en_next;
      overlay_en_reg <= overlay_en_next;
      break_en_reg <= break_en_next;
      high_cmp_reg <= high_cmp_next;
      high_mask_reg <= high_mask_next;
      brk_stat_reg <= brk_stat_next;
      debug_interrupt_flag_reg <= debug_interrupt_flag_next;
      evt_stat_reg <= evt_stat_next;
      evt_en_reg <= evt_en_next;
      pend_reg <= pend_next;
      exc_reg <= exc_next;
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
  assign debug_exception = exc_reg;
  assign debug_interrupt_flag = debug_interrupt_flag_reg;
  assign irq = |(evt_stat_reg & evt_en_reg);

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_break_sets_status: assert property (break_hit |=> brk_stat_reg && debug_interrupt_flag_reg)
    else $error("break match did not set status and debug interrupt");
  a_exc_held_in_dm: assert property (debug_mode_indicator |=> !exc_reg)
    else $error("debug exception raised while in debug mode");
  a_exc_follows_hit: assert property (
    break_hit && !debug_mode_indicator ##1 !debug_mode_indicator |=> exc_reg)
    else $error("debug exception missing two cycles after break match");
  a_break_needs_en: assert property (!break_en_reg |-> !break_hit)
    else $error("break match while break disabled");
  a_overlay_needs_en: assert property (overlay_redirect |-> overlay_en_reg && bus_valid)
    else $error("redirect without overlay enable");
  a_cached_load_none: assert property (bus_store == 1'b0 && bus_cached |-> !break_hit
    && !overlay_redirect)
    else $error("cached load matched");
  a_cached_store_gate: assert property (bus_store && bus_cached && !cached_en_reg |->
    !break_hit && !overlay_redirect)
    else $error("cached store matched while disabled");
  a_uncached_store_gate: assert property (bus_store && !bus_cached && !uncached_en_reg |->
    !break_hit && !overlay_redirect)
    else $error("uncached store matched while disabled");
  a_ctrl_read_fixed: assert property (setup && paddr == bbm_pkg::OFF_CTRL_MASK |=>
    prdata[5:1] == {bbm_pkg::UNC_LOAD_FETCH_VAL, overlay_en_reg, 2'h0})
    else $error("control reserved or qualifier bits read wrong");
  a_high_read_zero: assert property (setup && paddr == bbm_pkg::OFF_HIGH_CMP |=>
    prdata[31:4] == 28'h000_0000)
    else $error("high compare reserved bits not zero");
  a_data_mask_all: assert property (break_en_reg && qualified && brk_addr_eq &&
    dmask_reg == 32'hffff_ffff |-> break_hit)
    else $error("fully masked data blocked a break");
  a_addr_mid_cmp: assert property (break_hit |-> bus_addr[31:24] == low_cmp_reg[31:24])
    else $error("break ignored address bits 31:24");

endmodule : bbm_break_match

// *** verif/bbm_core_model.sv ***
/*
 * Processor core bus model: issues one-cycle bus transactions and drives
 * the debug mode level seen by the bus break comparator.
 * Assumes ref_clk is the core clock; all changes follow a rising edge.
 */
module bbm_core_model (
  // clock
  input wire logic ref_clk,
  // core bus
  output logic bus_valid,
  output logic bus_store,
  output logic bus_cached,
  output logic [35:0] bus_addr,
  output logic [31:0] bus_data,
  output logic debug_mode_indicator
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bus_valid = 1'b0;
    bus_store = 1'b0;
    bus_cached = 1'b0;
    bus_addr = 36'h0_0000_0000;
    bus_data = 32'h0000_0000;
    debug_mode_indicator = 1'b0;
  end

  // ==========================================================
  // transactions
  // idle bus shows the inverse, so a stale value can never match by accident
  task automatic access(input logic st, input logic ca, input logic [35:0] a,
                        input logic [31:0] d);
    @(posedge ref_clk);
    bus_valid <= 1'b1;
    bus_store <= st;
    bus_cached <= ca;
    bus_addr <= a;
    bus_data <= d;
    @(posedge ref_clk);
    bus_valid <= 1'b0;
    bus_addr <= ~a;
    bus_data <= ~d;
  endtask : access

  task automatic set_dm(input logic v);
    @(posedge ref_clk);
    debug_mode_indicator <= v;
  endtask : set_dm
endmodule : bbm_core_model

// *** verif/tb_bbm_break_match.sv ***
/*
 * Self-checking bench for bbm_break_match: APB register tasks, break,
 * overlay and interrupt scenarios.
 * Assumes bbm_core_model drives the core bus side.
 */
module tb_bbm_break_match;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_valid, bus_store, bus_cached, dm;
  logic [35:0] bus_addr;
  logic [31:0] bus_data;
  logic overlay_redirect, debug_exception, debug_interrupt_flag, irq;
  logic [31:0] rd_data;
  logic rd_err;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pulses;
  localparam logic [35:0] HIT_A = 36'h5_1234_5600;
  localparam logic [31:0] HIT_D = 32'hcafe_1200;

  always #20 ref_clk = ~ref_clk;

  bbm_break_match u_bbm_break_match (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_valid(bus_valid), .bus_store(bus_store),
    .bus_cached(bus_cached), .bus_addr(bus_addr), .bus_data(bus_data),
    .debug_mode_indicator(dm), .overlay_redirect(overlay_redirect),
    .debug_exception(debug_exception), .debug_interrupt_flag(debug_interrupt_flag),
    .irq(irq));

  bbm_core_model u_bbm_core_model (.ref_clk(ref_clk), .bus_valid(bus_valid),
    .bus_store(bus_store), .bus_cached(bus_cached), .bus_addr(bus_addr),
    .bus_data(bus_data), .debug_mode_indicator(dm));

  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================================
  // apb master
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write land before callers look at outputs it drives
    #1;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd_data, exp);
  endtask : rd_chk

  // one core access; overlay looked at in its own cycle, exception two edges on
  task automatic hit(input logic st, input logic ca, input logic [35:0] a,
                     input logic [31:0] d, input logic ov, input logic ex);
    fork
      u_bbm_core_model.access(st, ca, a, d);
      begin
        @(posedge ref_clk);
        #1 check(overlay_redirect, ov);
      end
    join
    @(posedge ref_clk);
    #1 check(debug_exception, ex);
  endtask : hit

  // ==========================================================
  // scenarios
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(12'h30c, 32'h0000_0030);
    for (int i = 0; i < 10; i++) begin
      if (i != 3 && i != 8) rd_chk(12'h300 + 12'(4 * i), 32'h0000_0000);
    end
    apb(1'b1, 12'h30c, 32'hffff_fffe);
    rd_chk(12'h30c, 32'hffff_fff8);
    apb(1'b1, 12'h310, 32'hffff_ffff);
    rd_chk(12'h310, 32'h0000_000f);
    apb(1'b0, 12'h328, 32'h0000_0000);
    check(rd_err, 1'b1);
    check(rd_data, 32'h0000_0000);
    // break path: low data byte masked, cached stores and uncached loads compared
    apb(1'b1, 12'h300, 32'h1234_5600);
    apb(1'b1, 12'h304, HIT_D);
    apb(1'b1, 12'h308, 32'hff00_00ff);
    apb(1'b1, 12'h310, 32'h0000_0005);
    apb(1'b1, 12'h314, 32'h0000_0000);
    apb(1'b1, 12'h30c, 32'h0000_0081);
    check(irq, 1'b0);
    hit(1'b1, 1'b1, HIT_A, HIT_D ^ 32'h0000_00a5, 1'b0, 1'b1);
    check(debug_interrupt_flag, 1'b1);
    rd_chk(12'h318, 32'h0000_0003);
    apb(1'b1, 12'h318, 32'h0000_0000);
    rd_chk(12'h318, 32'h0000_0000);
    hit(1'b1, 1'b1, HIT_A, HIT_D ^ 32'h0000_0100, 1'b0, 1'b0);
    hit(1'b1, 1'b1, HIT_A ^ 36'h0_0000_0001, HIT_D, 1'b0, 1'b0);
    hit(1'b1, 1'b1, HIT_A ^ 36'h0_0100_0000, HIT_D, 1'b0, 1'b0);
    hit(1'b1, 1'b0, HIT_A, HIT_D, 1'b0, 1'b0);
    hit(1'b0, 1'b0, HIT_A, HIT_D, 1'b0, 1'b1);
    hit(1'b0, 1'b1, HIT_A, HIT_D, 1'b0, 1'b0);
    // low address byte masked, uncached stores and loads only
    apb(1'b1, 12'h30c, 32'h0000_ff41);
    hit(1'b1, 1'b1, HIT_A, HIT_D, 1'b0, 1'b0);
    hit(1'b1, 1'b0, HIT_A ^ 36'h0_0000_00ff, HIT_D, 1'b0, 1'b1);
    hit(1'b1, 1'b0, HIT_A ^ 36'h3_0000_0000, HIT_D, 1'b0, 1'b0);
    apb(1'b1, 12'h314, 32'h0000_0003);
    hit(1'b1, 1'b0, HIT_A ^ 36'h3_0000_0000, HIT_D, 1'b0, 1'b1);
    // exception held while the handler runs
    u_bbm_core_model.set_dm(1'b1);
    hit(1'b1, 1'b0, HIT_A, HIT_D, 1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1 check(debug_exception, 1'b0);
    u_bbm_core_model.set_dm(1'b0);
    pulses = 0;
    repeat (4) begin
      @(posedge ref_clk);
      #1 pulses += int'(debug_exception === 1'b1);
    end
    check(pulses, 32'd1);
    // overlay: upper mask drops address bits 31:24, data ignored
    apb(1'b1, 12'h30c, 32'h0000_0008);
    apb(1'b1, 12'h314, 32'h0000_0000);
    hit(1'b0, 1'b0, HIT_A ^ 36'h0_ff00_0000, ~HIT_D, 1'b1, 1'b0);
    hit(1'b0, 1'b0, HIT_A ^ 36'h0_0000_0100, HIT_D, 1'b0, 1'b0);
    hit(1'b1, 1'b1, HIT_A, HIT_D, 1'b0, 1'b0);
    // events and the interrupt line
    rd_chk(12'h31c, 32'h0000_0003);
    apb(1'b1, 12'h324, 32'h0000_0001);
    check(irq, 1'b1);
    apb(1'b1, 12'h320, 32'h0000_0001);
    rd_chk(12'h31c, 32'h0000_0002);
    check(irq, 1'b0);
    apb(1'b1, 12'h324, 32'h0000_0002);
    check(irq, 1'b1);
    apb(1'b1, 12'h320, 32'h0000_0002);
    check(irq, 1'b0);
    rd_chk(12'h320, 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_bbm_break_match
